// ==== design/abn_enc_defines.svh ====
// Purpose: constants for the quadrature encoder counter
// Assumes: included by the design files by bare name
// Notes: register offsets are word indexes on the Avalon address
`ifndef ABN_ENC_DEFINES_SVH
`define ABN_ENC_DEFINES_SVH

// Register word indexes
`define ENC_OFS_MODE 3'h0
`define ENC_OFS_INCR 3'h1
`define ENC_OFS_POS 3'h2
`define ENC_OFS_LATCH 3'h3
`define ENC_OFS_STATUS 3'h4
`define ENC_OFS_MASK 3'h5
`define ENC_OFS_DEVLIM 3'h6

// Status and mask bit positions
`define ENC_ST_INDEX_CLR 0
`define ENC_ST_DEVIATION 1

// Reset values
`define ENC_RST_MODE 9'h000
`define ENC_RST_INCR 32'h0001_0000
`define ENC_RST_DEVLIM 32'hFFFF_FFFF

// Timing and arithmetic
`define ENC_FILT_CYCLES 3
`define ENC_DEC_BASE 17'h02710

`endif

// ==== design/abn_enc_pkg.sv ====
// Purpose: shared types of the quadrature encoder counter
// Assumes: nothing beyond SystemVerilog
// Notes: mode_t is the layout of the mode register, bit 0 lowest
package abn_enc_pkg;

  // Mode register fields, MSB first
  typedef struct packed {
    logic decimal;  // Bit 8: decimal fraction format
    logic inv_b;    // Bit 7: B channel active low
    logic inv_a;    // Bit 6: A channel active low
    logic clr_enc;  // Bit 5: index clears the position
    logic clr_once; // Bit 4: act on next index only
    logic clr_cont; // Bit 3: act on every index
    logic pol_n;    // Bit 2: index active level
    logic pol_b;    // Bit 1: B level that qualifies index
    logic pol_a;    // Bit 0: A level that qualifies index
  } mode_t;

endpackage

// ==== design/abn_encoder_counter.sv ====
// Purpose: ABN quadrature encoder counter with index clear and latch
// Assumes: Avalon-MM slave on SYS_CLK, word addressing
// Notes: encoder pins are filtered and synchronised before use
`timescale 1ns/10ps
`include "abn_enc_defines.svh"

// Notes on behaviour
// - Accepted index clears or latches the position
// - Continuous mode acts on every accepted index
// - Single-shot mode acts once, then disarms itself
// - Index accepted only at selected A/B levels
// - Clear needs clear bit and an armed mode
// - Each A or B change adds or subtracts increment
// - Binary increment is signed 16.16 fixed point
// - Decimal fraction counts ten-thousandths, wraps at 10000
// - Negative increment reverses counting direction
// - Position always readable; selectable input polarities
// - Index clear sets a readable status flag
// - Accepted index copies position into latch
// - Edge rate limited to two thirds clock
// - Pulses under three clocks are suppressed
// - Deviation beyond limit raises step-loss interrupt
module abn_encoder_counter (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Avalon-MM slave
  input wire logic [2:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // Encoder pins
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic ENC_N,
  // Motor position for deviation check
  input wire logic [31:0] MOTOR_POS,
  // Results
  output logic [31:0] ENC_POS,
  output logic IRQ
);
  typedef struct packed {
    abn_enc_pkg::mode_t mode;
    logic [31:0] incr;
    logic [31:0] pos_int;
    logic [15:0] pos_frac;
    logic [31:0] latch;
    logic [1:0] status;
    logic [1:0] mask;
    logic [31:0] dev_limit;
    logic [1:0] ab_prev;
    logic idx_prev;
    logic rd_done;
    logic [31:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;
  logic [2:0] pins;
  logic [2:0] filt;
  logic a;
  logic b;
  logic n_act;
  logic one_change;
  logic fwd;
  logic step;
  logic idx_qual;
  logic idx_trig;
  logic [31:0] sum_int;
  logic [15:0] sum_frac;
  logic [32:0] diff;
  logic [31:0] dev_abs;
  logic dev_ev;
  logic wr_pos;
  logic rd_take;
  logic [31:0] rd_mux;

  // Byte-lane merge of a write into a register value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Spike filter on each encoder pin
  assign pins = {ENC_N, ENC_B, ENC_A};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_filt
      enc_glitch_filter #(
        .FILT_LEN(`ENC_FILT_CYCLES)
      ) u_filt (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .raw(pins[g]),
        .filtered(filt[g])
      );
    end
  endgenerate

  // Input polarity and quadrature decode
  always_comb begin
    a = filt[0] ^ st.mode.inv_a;
    b = filt[1] ^ st.mode.inv_b;
    n_act = ~(filt[2] ^ st.mode.pol_n);
    one_change = (a ^ st.ab_prev[1]) ^ (b ^ st.ab_prev[0]);
    fwd = a ^ st.ab_prev[0];
    step = one_change;
  end

  // Index qualification and arming
  always_comb begin
    idx_qual = n_act && (a == st.mode.pol_a) && (b == st.mode.pol_b);
    idx_trig = idx_qual && !st.idx_prev
      && (st.mode.clr_cont || st.mode.clr_once);
  end

  // Fixed-point step, sign of increment sets effective direction
  enc_step_adder u_add (
    .pos_int(st.pos_int),
    .pos_frac(st.pos_frac),
    .incr(st.incr),
    .decimal(st.mode.decimal),
    .sub(!fwd),
    .sum_int(sum_int),
    .sum_frac(sum_frac)
  );

  // Motor to encoder mismatch
  always_comb begin
    diff = {MOTOR_POS[31], MOTOR_POS} - {st.pos_int[31], st.pos_int};
    dev_abs = diff[32] ? 32'(-diff) : diff[31:0];
    dev_ev = dev_abs > st.dev_limit;
  end

  // Bus decode: reads take one wait cycle, writes none
  always_comb begin
    wr_pos = WRITE && (ADDRESS == `ENC_OFS_POS);
    rd_take = READ && st.rd_done;
    unique case (ADDRESS)
      `ENC_OFS_MODE: rd_mux = {23'h000000, st.mode};
      `ENC_OFS_INCR: rd_mux = st.incr;
      `ENC_OFS_POS: rd_mux = st.pos_int;
      `ENC_OFS_LATCH: rd_mux = st.latch;
      `ENC_OFS_STATUS: rd_mux = {30'h00000000, st.status};
      `ENC_OFS_MASK: rd_mux = {30'h00000000, st.mask};
      `ENC_OFS_DEVLIM: rd_mux = st.dev_limit;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Next state
  always_comb begin
    next_st = st;
    next_st.ab_prev = {a, b};
    next_st.idx_prev = idx_qual;
    next_st.rd_done = READ && !st.rd_done;
    if (READ && !st.rd_done) begin
      next_st.rdata = rd_mux;
    end
    if (step) begin
      next_st.pos_int = sum_int;
      next_st.pos_frac = sum_frac;
    end
    if (idx_trig) begin
      next_st.latch = st.pos_int;
      if (st.mode.clr_enc) begin
        next_st.pos_int = 32'h00000000;
        next_st.pos_frac = 16'h0000;
      end
      if (st.mode.clr_once) begin
        next_st.mode.clr_once = 1'b0;
      end
    end
    // Read clears only the status bits that were returned
    if (rd_take && (ADDRESS == `ENC_OFS_STATUS)) begin
      next_st.status = st.status & ~st.rdata[1:0];
    end
    // Hardware events win over the read clear
    if (idx_trig && st.mode.clr_enc) begin
      next_st.status[`ENC_ST_INDEX_CLR] = 1'b1;
    end
    if (dev_ev) begin
      next_st.status[`ENC_ST_DEVIATION] = 1'b1;
    end
    if (WRITE) begin
      unique case (ADDRESS)
        `ENC_OFS_MODE: next_st.mode = 9'(merge({23'h000000, st.mode}, WRITEDATA, BYTEENABLE));
        `ENC_OFS_INCR: next_st.incr = merge(st.incr, WRITEDATA, BYTEENABLE);
        `ENC_OFS_POS: begin
          next_st.pos_int = merge(st.pos_int, WRITEDATA, BYTEENABLE);
          next_st.pos_frac = 16'h0000;
        end
        `ENC_OFS_MASK: next_st.mask = 2'(merge({30'h0, st.mask}, WRITEDATA, BYTEENABLE));
        `ENC_OFS_DEVLIM: next_st.dev_limit = merge(st.dev_limit, WRITEDATA, BYTEENABLE);
        default: next_st.mode = st.mode;
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      st <= '0;
      st.mode <= `ENC_RST_MODE;
      st.incr <= `ENC_RST_INCR;
      st.dev_limit <= `ENC_RST_DEVLIM;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign READDATA = st.rdata;
  assign WAITREQUEST = READ && !st.rd_done;
  assign ENC_POS = st.pos_int;
  assign IRQ = |(st.status & st.mask);

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_read_wait;
    READ && WAITREQUEST;
  endsequence
  sequence s_read_done;
    READ && !WAITREQUEST;
  endsequence

  property p_latch_on_index;
    idx_trig |=> st.latch == $past(st.pos_int);
  endproperty
  a_latch_on_index: assert property (p_latch_on_index)
    else $error("latch did not take the position on index");

  property p_clear_on_index;
    idx_trig && st.mode.clr_enc && !wr_pos |=> st.pos_int == 32'h0 && st.status[0];
  endproperty
  a_clear_on_index: assert property (p_clear_on_index)
    else $error("index did not clear the position");

  property p_once_disarm;
    idx_trig && st.mode.clr_once && !WRITE |=> !st.mode.clr_once;
  endproperty
  a_once_disarm: assert property (p_once_disarm)
    else $error("single-shot index stayed armed");

  property p_cont_stays;
    idx_trig && st.mode.clr_cont && !WRITE |=> st.mode.clr_cont;
  endproperty
  a_cont_stays: assert property (p_cont_stays)
    else $error("continuous index disarmed");

  property p_index_qualified;
    idx_trig |-> (a == st.mode.pol_a) && (b == st.mode.pol_b) && n_act;
  endproperty
  a_index_qualified: assert property (p_index_qualified)
    else $error("index taken at wrong A/B levels");

  property p_fwd_step;
    step && fwd && !st.mode.decimal && !idx_trig && !wr_pos
      |=> {st.pos_int, st.pos_frac}
        == $past({st.pos_int, st.pos_frac}) + {{16{$past(st.incr[31])}}, $past(st.incr)};
  endproperty
  a_fwd_step: assert property (p_fwd_step)
    else $error("forward step did not add the increment");

  property p_dec_range;
    st.mode.decimal && st.pos_frac < 16'h2710 && st.incr[15:0] < 16'h2710
      && !wr_pos |=> st.pos_frac < 16'h2710;
  endproperty
  a_dec_range: assert property (p_dec_range)
    else $error("decimal fraction left its range");

  property p_deviation;
    dev_ev |=> st.status[1];
  endproperty
  a_deviation: assert property (p_deviation)
    else $error("deviation not flagged");

  property p_read_answer;
    s_read_wait |=> s_read_done;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered after one wait cycle");

  // Backward binary step takes the increment off the whole 16.16 value
  property p_bwd_step;
    step && !fwd && !st.mode.decimal && !idx_trig && !wr_pos
      |=> {st.pos_int, st.pos_frac}
        == $past({st.pos_int, st.pos_frac}) - {{16{$past(st.incr[31])}}, $past(st.incr)};
  endproperty
  a_bwd_step: assert property (p_bwd_step)
    else $error("backward step did not subtract the increment");

  // Without a step, an index or a write the position stays put
  property p_pos_quiet;
    !step && !idx_trig && !wr_pos |=> $stable(st.pos_int) && $stable(st.pos_frac);
  endproperty
  a_pos_quiet: assert property (p_pos_quiet)
    else $error("position moved without a step");

  // Latch only changes on an accepted index
  property p_latch_hold;
    !idx_trig |=> $stable(st.latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch changed without an index");

  // Index flag holds until a status read returns it
  property p_index_flag_sticky;
    st.status[`ENC_ST_INDEX_CLR] && !(rd_take && (ADDRESS == `ENC_OFS_STATUS))
      |=> st.status[`ENC_ST_INDEX_CLR];
  endproperty
  a_index_flag_sticky: assert property (p_index_flag_sticky)
    else $error("index flag dropped without a read");

  // With neither index mode armed, an index does nothing
  property p_disarmed_quiet;
    !st.mode.clr_once && !st.mode.clr_cont |=> $stable(st.latch) && !$rose(st.status[0]);
  endproperty
  a_disarmed_quiet: assert property (p_disarmed_quiet)
    else $error("index acted while disarmed");

  // Decimal forward step moves the integer part by the factor or one more
  property p_dec_fwd;
    step && fwd && st.mode.decimal && !idx_trig && !wr_pos
      |=> 32'(st.pos_int - $past(st.pos_int)
        - {{16{$past(st.incr[31])}}, $past(st.incr[31:16])}) <= 32'h1;
  endproperty
  a_dec_fwd: assert property (p_dec_fwd)
    else $error("decimal step carried wrongly");
endmodule

// ==== design/enc_glitch_filter.sv ====
// Purpose: two-stage synchroniser and spike filter for one encoder pin
// Assumes: pin is asynchronous to clk
// Notes: a level is taken only after FILT_LEN equal samples
`timescale 1ns/10ps
`include "abn_enc_defines.svh"
module enc_glitch_filter #(
  parameter int FILT_LEN = `ENC_FILT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and filtered level
  input wire logic raw,
  output logic filtered
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [3:0] cnt;
    logic out;
  } filt_t;

  filt_t st;
  filt_t next_st;

  // Count samples that differ from the output, restart on agreement
  always_comb begin
    next_st = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    if (st.s2 == st.out) begin
      next_st.cnt = 4'h0;
    end else if (st.cnt == 4'(FILT_LEN - 1)) begin
      next_st.out = st.s2;
      next_st.cnt = 4'h0;
    end else begin
      next_st.cnt = st.cnt + 4'h1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign filtered = st.out;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_spike_reject;
    $changed(st.out) |-> ($past(st.s2, 1) == st.out) && ($past(st.s2, 2) == st.out)
      && ($past(st.s2, 3) == st.out);
  endproperty
  a_spike_reject: assert property (p_spike_reject)
    else $error("filter output moved on a short pulse");
endmodule

// ==== design/enc_step_adder.sv ====
// Purpose: adds or subtracts the increment to the position
// Assumes: decimal fraction inputs stay within 0 to 9999
// Notes: purely combinational
`timescale 1ns/10ps
`include "abn_enc_defines.svh"
module enc_step_adder (
  // Present position and increment
  input wire logic [31:0] pos_int,
  input wire logic [15:0] pos_frac,
  input wire logic [31:0] incr,
  input wire logic decimal,
  input wire logic sub,
  // New position
  output logic [31:0] sum_int,
  output logic [15:0] sum_frac
);
  logic [47:0] bin;
  logic [47:0] ext;
  logic [16:0] f;
  logic [31:0] ci;
  logic carry;

  // Binary 16.16 or decimal fraction in ten-thousandths
  always_comb begin
    ext = {{16{incr[31]}}, incr};
    bin = sub ? {pos_int, pos_frac} - ext : {pos_int, pos_frac} + ext;
    ci = {{16{incr[31]}}, incr[31:16]};
    carry = 1'b0;
    if (sub) begin
      f = {1'b0, pos_frac} - {1'b0, incr[15:0]};
      if (f[16]) begin
        f = f + `ENC_DEC_BASE;
        carry = 1'b1;
      end
    end else begin
      f = {1'b0, pos_frac} + {1'b0, incr[15:0]};
      if (f >= `ENC_DEC_BASE) begin
        f = f - `ENC_DEC_BASE;
        carry = 1'b1;
      end
    end
    if (decimal) begin
      sum_int = sub ? pos_int - ci - {31'h0, carry} : pos_int + ci + {31'h0, carry};
      sum_frac = f[15:0];
    end else begin
      sum_int = bin[47:16];
      sum_frac = bin[15:0];
    end
  end
endmodule

// ==== tb/enc_model.sv ====
// Purpose: behavioural incremental encoder driving A, B and index
// Assumes: driven by task calls from the bench
// Notes: step levels are held far longer than the input filter; pulse takes its width w from the bench
`timescale 1ns/10ps
module enc_model (
  // Clock
  input wire logic clk,
  // Encoder pins
  output logic enc_a,
  output logic enc_b,
  output logic enc_n
);
  int q = 0;

  // Idle levels from time zero
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    enc_n = 1'b0;
  end

  // Hold a level; keeps edge rate well under the counting limit
  task hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Phase order 00,10,11,01 (A,B) is forward
  task step(input bit fwd);
    q = fwd ? (q + 1) % 4 : (q + 3) % 4;
    @(posedge clk);
    enc_a <= (q == 1) || (q == 2);
    enc_b <= (q == 2) || (q == 3);
    hold(10);
  endtask

  // Pulse of w clocks on index, or a spike on A
  task pulse(input int w, input bit ch_a);
    @(posedge clk);
    if (ch_a) enc_a <= !enc_a;
    else enc_n <= 1'b1;
    hold(w);
    if (ch_a) enc_a <= !enc_a;
    else enc_n <= 1'b0;
    hold(10);
  endtask
endmodule

// ==== tb/tb.sv ====
// Purpose: self-checking bench of the quadrature encoder counter
// Assumes: one clock, registers over Avalon-MM
// Notes: expected positions come from exact fixed-point sums
`timescale 1ns/10ps
`include "abn_enc_defines.svh"
module tb;
  logic SYS_CLK, RESET_N, READ, WRITE, ENC_A, ENC_B, ENC_N, WAITREQUEST, IRQ;
  logic [2:0] ADDRESS;
  logic [31:0] WRITEDATA, READDATA, MOTOR_POS, ENC_POS, rd;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam longint BASE = 64'h2710;

  abn_encoder_counter DUT (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .ADDRESS(ADDRESS),
    .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(4'hF),
    .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .ENC_A(ENC_A), .ENC_B(ENC_B),
    .ENC_N(ENC_N), .MOTOR_POS(MOTOR_POS), .ENC_POS(ENC_POS), .IRQ(IRQ));
  enc_model u_enc (.clk(SYS_CLK), .enc_a(ENC_A), .enc_b(ENC_B), .enc_n(ENC_N));

  // Clock
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end

  // Hang guard
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      conclude();
    end
  end

  task conclude();
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle, held until waitrequest is seen low
  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    WRITE <= w;
    READ <= !w;
    ADDRESS <= a;
    WRITEDATA <= d;
    do begin
      @(posedge SYS_CLK);
    end while (WAITREQUEST !== 1'b0);
    rd = READDATA;
    WRITE <= 1'b0;
    READ <= 1'b0;
  endtask

  task rchk(input logic [2:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Integer part after k net forward steps, floor rounding
  function automatic logic [31:0] exp_pos(input logic [31:0] inc, input int k, input bit dec);
    longint t, q;
    if (!dec) return 32'((longint'(signed'(inc)) * k) >>> 16);
    t = (longint'(signed'(inc[31:16])) * BASE + longint'(inc[15:0])) * k;
    q = t / BASE;
    if (t < 0 && t % BASE != 0) q--;
    return q[31:0];
  endfunction

  // Count nf steps forward and nb back
  task run(input logic [31:0] inc, input bit dec, input int nf, input int nb);
    bus(1'b1, `ENC_OFS_MODE, {23'h0, dec, 8'h00});
    bus(1'b1, `ENC_OFS_INCR, inc);
    bus(1'b1, `ENC_OFS_POS, 32'h0);
    repeat (nf) u_enc.step(1'b1);
    repeat (nb) u_enc.step(1'b0);
    chk(ENC_POS, exp_pos(inc, nf - nb, dec));
    rchk(`ENC_OFS_POS, exp_pos(inc, nf - nb, dec));
  endtask

  // Index pulse with A and B both high
  task idx(input logic [8:0] md, input logic [31:0] p, input logic [31:0] ep,
    input logic [31:0] el, input logic [31:0] es);
    while (u_enc.q != 2) u_enc.step(1'b1);
    bus(1'b1, `ENC_OFS_MODE, {23'h0, md});
    bus(1'b1, `ENC_OFS_POS, p);
    u_enc.pulse(5, 1'b0);
    chk(IRQ, es[0]);
    chk(ENC_POS, ep);
    rchk(`ENC_OFS_LATCH, el);
    rchk(`ENC_OFS_STATUS, es);
    @(posedge SYS_CLK);
    chk(IRQ, 1'b0);
  endtask

  // Main sequence
  initial begin
    READ = 1'b0;
    WRITE = 1'b0;
    ADDRESS = 3'h0;
    WRITEDATA = 32'h0;
    MOTOR_POS = 32'h0;
    RESET_N = 1'b0;
    void'($urandom(13));
    repeat (10) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    rchk(`ENC_OFS_MODE, 32'h0);
    rchk(`ENC_OFS_INCR, 32'h0001_0000);
    rchk(`ENC_OFS_DEVLIM, 32'hFFFF_FFFF);
    rchk(`ENC_OFS_MASK, 32'h0);
    bus(1'b1, `ENC_OFS_LATCH, 32'h1234);
    rchk(`ENC_OFS_LATCH, 32'h0);
    bus(1'b1, 3'h7, 32'h1234);
    rchk(3'h7, 32'h0);
    run(32'h0001_0000, 1'b0, 9, 3);
    run(32'hFFFF_0000, 1'b0, 7, 2);
    run(32'h0019_1770, 1'b1, 5, 0);
    run(32'hFFE6_0FA0, 1'b1, 5, 1);
    run(32'h0033_07D0, 1'b1, 3, 4);
    repeat (3) begin
      run({16'($urandom_range(0, 511)) - 16'h0100, 16'($urandom)}, 1'b0,
        $urandom_range(1, 12), $urandom_range(0, 6));
      run({16'($urandom_range(0, 99)), 16'($urandom_range(0, 9999))}, 1'b1,
        $urandom_range(1, 12), $urandom_range(0, 6));
    end
    // Short spike on A must not count
    run(32'h0001_0000, 1'b0, 2, 0);
    fork
      u_enc.pulse(2, 1'b1);
      repeat (12) begin
        @(posedge SYS_CLK);
        chk(ENC_POS, 32'h2);
      end
    join
    chk(ENC_POS, 32'h2);
    // Index actions
    bus(1'b1, `ENC_OFS_MASK, 32'h1);
    idx(9'h02F, 32'h55, 32'h0, 32'h55, 32'h1);
    idx(9'h02F, 32'h66, 32'h0, 32'h66, 32'h1);
    idx(9'h02E, 32'h77, 32'h77, 32'h66, 32'h0);
    idx(9'h037, 32'h88, 32'h0, 32'h88, 32'h1);
    rchk(`ENC_OFS_MODE, 32'h027);
    idx(9'h027, 32'h99, 32'h99, 32'h88, 32'h0);
    idx(9'h00F, 32'hAA, 32'hAA, 32'hAA, 32'h0);
    // Inverted A and B qualify the index at low levels
    idx(9'h0EC, 32'hBB, 32'h0, 32'hBB, 32'h1);
    // Deviation limit, boundary then beyond
    bus(1'b1, `ENC_OFS_POS, 32'h0);
    bus(1'b1, `ENC_OFS_DEVLIM, 32'h5);
    bus(1'b1, `ENC_OFS_MASK, 32'h2);
    MOTOR_POS <= 32'h5;
    repeat (3) @(posedge SYS_CLK);
    rchk(`ENC_OFS_STATUS, 32'h0);
    MOTOR_POS <= 32'hFFFF_FFFA;
    repeat (3) @(posedge SYS_CLK);
    chk(IRQ, 1'b1);
    rchk(`ENC_OFS_STATUS, 32'h2);
    bus(1'b1, `ENC_OFS_MASK, 32'h0);
    repeat (2) @(posedge SYS_CLK);
    chk(IRQ, 1'b0);
    conclude();
  end
endmodule
